/* dv/host_model.sv */
`timescale 1ns/10ps
module host_model
  import xcvr_status_pkg::*;
(
  input wire logic clk_sys_i, // Clock
  input wire logic rvalid_i, // Read valid
  input wire logic [7:0] rdata_i, // Read data
  output logic [7:0] addr_o, // Offset
  output logic wr_o, // Write strobe
  output logic [7:0] wdata_o, // Write data
  output logic rd_o // Read strobe
);
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // ****
  // Bus cycles
  // ****
  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Strobe held n cycles gives n back-to-back reads
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d, output bit ok);
    int i;
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    repeat (n) @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_sys_i);
    for (i = 0; i < 4 && rvalid_i !== 1'b1; i++)
      @(posedge clk_sys_i);
    d = rdata_i;
    ok = (rvalid_i === 1'b1);
  endtask
endmodule

/* dv/xcvr_status_regs_asserts.sv */
`timescale 1ns/10ps
module xcvr_status_regs_asserts
  import xcvr_status_pkg::*;
#(parameter logic [7:0] SILICON_REV = 8'h00)
(
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic [7:0] reg_addr_i, // Offset
  input wire logic reg_wr_i, // Write
  input wire logic reg_rd_i, // Read
  input wire logic supply_shutdown_i, // In
  input wire logic thermal_shutdown_i, // In
  input wire logic thermal_warning_i, // In
  input wire logic supply_low_i, // In
  input wire logic supply_high_i, // In
  input wire logic overcurrent_i, // In
  input wire logic transmit_enable_i, // In
  input wire logic link_idle_i, // Idle
  input wire logic [7:0] reg_rdata_o, // Data
  input wire logic reg_rvalid_o, // Valid
  input wire logic serial_diag_pin_oe_o, // Diag
  input wire logic driver_shutdown_o, // Shut
  input wire logic [7:0] driver_params_o, // Cfg
  input wire logic [7:0] protection_disable_o // Cfg
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Transmit low also clears wake and overload latches
  wire [6:0] ev = {supply_shutdown_i, thermal_shutdown_i, thermal_warning_i, supply_low_i, supply_high_i,
    overcurrent_i, transmit_enable_i};
  // ****
  // Assertions
  // ****
  sequence s_quiet;
    (ev == 7'h00) [*6];
  endsequence
  sequence s_rd0;
    reg_rd_i && reg_addr_i == 8'h00;
  endsequence
  property p_clear;
    s_quiet ##0 s_rd0 ##1 s_rd0 |=> reg_rdata_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept after read");
  property p_rd_ans;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_only;
    !reg_rd_i |=> !reg_rvalid_o;
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("stray read valid");
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_idle;
    !link_idle_i |=> !serial_diag_pin_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("diag during busy link");
  property p_ro;
    reg_wr_i && (reg_addr_i == 8'h01 || reg_addr_i > 8'h08) |=> $stable({driver_params_o, protection_disable_o});
  endproperty
  a_ro: assert property (p_ro) else $error("ignored write took effect");
  property p_rev;
    reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o == SILICON_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_unmapped;
    reg_rd_i && reg_addr_i > 8'h08 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_shut;
    (protection_disable_o[1:0] == 2'b00 && $stable({supply_shutdown_i, thermal_shutdown_i})) [*4]
      |-> driver_shutdown_o == (supply_shutdown_i || thermal_shutdown_i);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown mismatch");
endmodule

/* dv/xcvr_status_regs_tb_top.sv */
`timescale 1ns/10ps
module xcvr_status_regs_tb_top
  import xcvr_status_pkg::*;
();
  localparam logic [7:0] REV = 8'h3c; // Arbitrary value
  typedef struct packed {cond_t c; logic [7:0] live; logic [7:0] flag;} row_t;
  logic clk_sys_i, rst_i, link_idle_i, wr, rd, rv, diag, oe, shut;
  logic [7:0] addr, wd, rdata, d, par, cta, ctb, prt, rol;
  cond_t c;
  bit ok;
  int errors, num_checks;
  logic [7:0] rst_tab [10] = '{8'h01, 8'h00, 8'hfb, 8'he3, 8'h23, 8'h00, 8'h00, 8'h00, REV, 8'h00};
  row_t rows [10] = '{{10'h200, 8'h40, 8'h80}, {10'h100, 8'h40, 8'h40}, {10'h080, 8'h20, 8'h20},
    {10'h040, 8'h10, 8'h10}, {10'h020, 8'h08, 8'h08}, {10'h011, 8'h04, 8'h04}, {10'h009, 8'h02, 8'h02},
    {10'h004, 8'h00, 8'h00}, {10'h002, 8'h80, 8'h00}, {10'h001, 8'h00, 8'h00}};
  xcvr_status_regs #(.STARTUP_CYCLES(8), .BLANK_STEP_CYCLES(4), .SILICON_REV(REV)) u_xcvr_status_regs (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .link_idle_i(link_idle_i), .supply_shutdown_i(c.supply_shutdown), .thermal_shutdown_i(c.thermal_shutdown),
    .thermal_warning_i(c.thermal_warning), .supply_low_i(c.supply_low), .supply_high_i(c.supply_high),
    .wake_detect_i(c.wake_detect), .overcurrent_i(c.overcurrent), .die_broken_i(c.die_broken),
    .receive_level_i(c.receive_level), .transmit_enable_i(c.transmit_enable), .reg_rdata_o(rdata),
    .reg_rvalid_o(rv), .serial_diag_pin_o(diag), .serial_diag_pin_oe_o(oe), .driver_shutdown_o(shut),
    .driver_params_o(par), .transceiver_ctrl_a_o(cta), .transceiver_ctrl_b_o(ctb), .protection_disable_o(prt),
    .host_role_cfg_o(rol));
  host_model u_host (.clk_sys_i(clk_sys_i), .rvalid_i(rv), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .wdata_o(wd), .rd_o(rd));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ****
  // Checking
  // ****
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task rdc(input logic [7:0] a, input int n, input logic [7:0] e);
    u_host.rd(a, n, d, ok);
    if (!ok)
    begin
      errors++;
      results();
    end
    else
      chk($sformatf("reg %h", a), e, d);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  initial
  begin
    c = '0;
    link_idle_i = 1'b1;
    rst_i = 1'b1;
    wt(16);
    rst_i <= 1'b0;
    wt(2);
    chk("diag oe", 8'h01, {7'h00, oe});
    chk("diag pin", 8'h00, {7'h00, diag});
    for (int k = 0; k < 10; k++)
      rdc(8'(k), 1, rst_tab[k]);
    rdc(8'h00, 2, 8'h00);
    // Drop conditions before the flag read to prove stickiness
    foreach (rows[i])
    begin
      c <= rows[i].c;
      wt(12);
      rdc(8'h01, 1, rows[i].live);
      chk("shutdown", {7'h00, rows[i].live[6]}, {7'h00, shut});
      c <= '0;
      wt(12);
      rdc(8'h01, 1, 8'h00);
      rdc(8'h00, 1, rows[i].flag);
    end
    u_host.wr(8'h02, 8'hef);
    c.supply_low <= 1'b1;
    wt(8);
    c <= '0;
    wt(4);
    chk("masked", 8'h00, {7'h00, oe});
    u_host.wr(8'h02, 8'hff);
    link_idle_i <= 1'b0;
    wt(4);
    chk("busy", 8'h00, {7'h00, oe});
    link_idle_i <= 1'b1;
    wt(2);
    chk("idle", 8'h01, {7'h00, oe});
    rdc(8'h00, 1, 8'h10);
    u_host.wr(8'h06, 8'hff);
    u_host.wr(8'h01, 8'hff);
    u_host.wr(8'h20, 8'h55);
    rdc(8'h06, 1, 8'h7f);
    c <= 10'h309;
    wt(12);
    rdc(8'h01, 1, 8'h00);
    c <= '0;
    wt(12);
    rdc(8'h00, 1, 8'hc0);
    u_host.wr(8'h06, 8'h00);
    // Longest blanking step outlasts this pulse
    u_host.wr(8'h05, 8'h0c);
    c <= 10'h009;
    wt(12);
    c <= '0;
    wt(8);
    rdc(8'h00, 1, 8'h00);
    u_host.wr(8'h03, 8'h5a);
    u_host.wr(8'h04, 8'ha5);
    u_host.wr(8'h07, 8'hff);
    rdc(8'h03, 1, 8'h5a);
    chk("params out", 8'h5a, par);
    chk("ctrl a out", 8'ha5, cta);
    chk("ctrl b out", 8'h0c, ctb);
    chk("prot out", 8'h00, prt);
    chk("role out", 8'h07, rol);
    // Second reset with the integrity loop open during start-up
    c <= 10'h004;
    rst_i <= 1'b1;
    wt(16);
    rst_i <= 1'b0;
    wt(20);
    c <= '0;
    wt(4);
    rdc(8'h01, 1, 8'h01);
    rdc(8'h00, 1, 8'h01);
    results();
  end
endmodule
bind xcvr_status_regs xcvr_status_regs_asserts #(.SILICON_REV(SILICON_REV)) u_chk (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .supply_shutdown_i(supply_shutdown_i), .thermal_shutdown_i(thermal_shutdown_i),
  .thermal_warning_i(thermal_warning_i), .supply_low_i(supply_low_i), .supply_high_i(supply_high_i),
  .overcurrent_i(overcurrent_i), .transmit_enable_i(transmit_enable_i), .link_idle_i(link_idle_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .serial_diag_pin_oe_o(serial_diag_pin_oe_o),
  .driver_shutdown_o(driver_shutdown_o), .driver_params_o(driver_params_o),
  .protection_disable_o(protection_disable_o));

/* hdl/cond_if.sv */
`timescale 1ns/10ps
interface cond_if;
  import xcvr_status_pkg::*;
  cond_t cond;
  modport src (output cond);
  modport dst (input cond);
endinterface

/* hdl/cond_sync.sv */
`timescale 1ns/10ps
module cond_sync
  import xcvr_status_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire cond_t raw_i, // Unsynchronised conditions
  cond_if.src out // Synchronised conditions
);

  sync_state_t r;
  sync_state_t next_r;

  // Second stage alone is visible outside
  always_comb
  begin
    next_r = r;
    next_r.s1 = raw_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign out.cond = r.s2;

endmodule

/* hdl/xcvr_status_map.svh */
// Functional notes
// - Flag register holds until read, read clears all
// - Power-on flag set after reset, unmaskable
// - Bit 7 records supply shutdown since read
// - Bit 6 records thermal shutdown since read
// - Bit 5 records thermal warning since read
// - Bit 4 records low supply warning since read
// - Bit 3 records high supply warning since read
// - Bit 2 records wake request since read
// - Bit 1 records overload beyond blanking time
// - Live register read-only, not sticky
// - Live bit 7 mirrors receive level
// - Live bit 6 shows driver shutdown
// - Live bit 5 shows thermal warning
// - Live bit 4 shows low supply
// - Live bit 3 shows high supply
// - Live bit 2 wake, cleared when transmit disabled
// - Live bit 1 shows driver overload
// - Die integrity sampled only during start-up
// - Diag pin signals enabled flags and the power-on flag
// - Diag indication deferred until link idle
// - Overload cleared by transmit low or disable
`ifndef XCVR_STATUS_MAP_SVH
`define XCVR_STATUS_MAP_SVH

// Register offsets
`define OFS_IRQ_FLAGS 8'h00
`define OFS_LIVE_FLAGS 8'h01
`define OFS_IRQ_MASK 8'h02
`define OFS_DRIVER_PARAMS 8'h03
`define OFS_CTRL_A 8'h04
`define OFS_CTRL_B 8'h05
`define OFS_PROT_DISABLE 8'h06
`define OFS_HOST_ROLE 8'h07
`define OFS_SILICON_REV 8'h08

// Flag and live bit positions
`define BIT_SUPPLY_SHUTDOWN 7
`define BIT_THERMAL_SHUTDOWN 6
`define BIT_THERMAL_WARNING 5
`define BIT_SUPPLY_LOW 4
`define BIT_SUPPLY_HIGH 3
`define BIT_WAKE 2
`define BIT_OVERCURRENT 1
`define BIT_POWER_ON 0
`define BIT_RECEIVE_LEVEL 7
`define BIT_SHUTDOWN_LIVE 6
`define BIT_DIE_BROKEN 0

// Field positions in configuration registers
`define BLANK_SEL_MSB 3
`define BLANK_SEL_LSB 2
`define BIT_DIS_OVERCURRENT 2
`define BIT_DIS_THERMAL 1
`define BIT_DIS_SUPPLY 0

// Reset values
`define RST_IRQ_FLAGS 8'h01
`define RST_IRQ_MASK 8'hfb
`define RST_DRIVER_PARAMS 8'he3
`define RST_CTRL_A 8'h23
`define RST_CTRL_B 8'h00
`define RST_PROT_DISABLE 8'h00
`define RST_HOST_ROLE 8'h00
// Arbitrary neutral value
`define RST_SILICON_REV 8'h5a

// Writable bits
`define WMASK_PROT_DISABLE 8'h7f
`define WMASK_HOST_ROLE 8'h07

// Timing
`define CLK_PERIOD_NS 10
`define STARTUP_TIME_NS 100000
`define BLANK_STEP_TIME_NS 10000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_STEP_CYCLES ((`BLANK_STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hdl/xcvr_status_pkg.sv */
package xcvr_status_pkg;

  // Conditions from pins and analog detectors
  typedef struct packed {
    logic supply_shutdown;
    logic thermal_shutdown;
    logic thermal_warning;
    logic supply_low;
    logic supply_high;
    logic wake_detect;
    logic overcurrent;
    logic die_broken;
    logic receive_level;
    logic transmit_enable;
  } cond_t;

  typedef enum logic [0:0] {
    PH_STARTUP,
    PH_RUN
  } phase_t;

  typedef struct packed {
    cond_t s1;
    cond_t s2;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] params;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] prot;
    logic [7:0] role;
    logic [7:0] rdata;
    logic rvalid;
    logic ovl_live;
    logic wake_live;
    logic shut_live;
    logic die_fault;
    logic [15:0] ovl_cnt;
    logic [15:0] start_cnt;
    phase_t phase;
    logic diag_oe;
  } regs_state_t;

endpackage

/* hdl/xcvr_status_regs.sv */
`timescale 1ns/10ps
`include "xcvr_status_map.svh"
module xcvr_status_regs
  import xcvr_status_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int BLANK_STEP_CYCLES = `BLANK_STEP_CYCLES,
  parameter logic [7:0] SILICON_REV = `RST_SILICON_REV
)
(
  input wire logic clk_sys_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous power-on reset
  input wire logic [7:0] reg_addr_i, // Register offset
  input wire logic reg_wr_i, // Write strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_rd_i, // Read strobe
  input wire logic link_idle_i, // Serial link is idle
  input wire logic supply_shutdown_i, // Supply below shutdown level
  input wire logic thermal_shutdown_i, // Temperature above shutdown level
  input wire logic thermal_warning_i, // Temperature above warning level
  input wire logic supply_low_i, // Supply below warning level
  input wire logic supply_high_i, // Supply above warning level
  input wire logic wake_detect_i, // Wake request detected
  input wire logic overcurrent_i, // Driver current over limit
  input wire logic die_broken_i, // Die integrity loop open
  input wire logic receive_level_i, // Receive data output level
  input wire logic transmit_enable_i, // Transmit enable pin
  output logic [7:0] reg_rdata_o, // Read data
  output logic reg_rvalid_o, // Read data valid pulse
  output logic serial_diag_pin_o, // Diag pin output level
  output logic serial_diag_pin_oe_o, // Diag pin pull-down enable
  output logic driver_shutdown_o, // Driver forced off
  output logic [7:0] driver_params_o, // Driver parameters
  output logic [7:0] transceiver_ctrl_a_o, // Transceiver control A
  output logic [7:0] transceiver_ctrl_b_o, // Transceiver control B
  output logic [7:0] protection_disable_o, // Protection disables
  output logic [7:0] host_role_cfg_o // Host role configuration
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  cond_t raw;
  cond_if sync_bus();

  always_comb
  begin
    raw.supply_shutdown = supply_shutdown_i;
    raw.thermal_shutdown = thermal_shutdown_i;
    raw.thermal_warning = thermal_warning_i;
    raw.supply_low = supply_low_i;
    raw.supply_high = supply_high_i;
    raw.wake_detect = wake_detect_i;
    raw.overcurrent = overcurrent_i;
    raw.die_broken = die_broken_i;
    raw.receive_level = receive_level_i;
    raw.transmit_enable = transmit_enable_i;
  end

  cond_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .raw_i(raw),
    .out(sync_bus.src)
  );

  // ****************************************
  // State
  // ****************************************
  regs_state_t r;
  regs_state_t next_r;
  cond_t c;
  logic ovl_allowed;
  logic [15:0] blank_lim;
  logic [7:0] live;
  logic [7:0] events;
  logic [7:0] pending;
  logic flags_read;
  logic [7:0] rd_value;

  assign c = sync_bus.cond;

  // ****************************************
  // Overload blanking window
  // ****************************************
  // Widened before the product so the longest setting cannot wrap
  always_comb
  begin
    ovl_allowed = c.transmit_enable && !r.prot[`BIT_DIS_OVERCURRENT];
    blank_lim = 16'((32'(r.ctrl_b[`BLANK_SEL_MSB:`BLANK_SEL_LSB]) + 32'd1) * BLANK_STEP_CYCLES);
  end

  // ****************************************
  // Sticky event sources
  // ****************************************
  always_comb
  begin
    events = 8'h00;
    events[`BIT_SUPPLY_SHUTDOWN] = c.supply_shutdown;
    events[`BIT_THERMAL_SHUTDOWN] = c.thermal_shutdown;
    events[`BIT_THERMAL_WARNING] = c.thermal_warning;
    events[`BIT_SUPPLY_LOW] = c.supply_low;
    events[`BIT_SUPPLY_HIGH] = c.supply_high;
    events[`BIT_WAKE] = r.wake_live;
    events[`BIT_OVERCURRENT] = r.ovl_live;
    flags_read = reg_rd_i && (reg_addr_i == `OFS_IRQ_FLAGS);
  end

  // ****************************************
  // Interrupt pin view
  // ****************************************
  // Power-on flag bypasses the mask
  assign pending = r.flags & {r.mask[7:1], 1'b1};

  // ****************************************
  // Read data select
  // ****************************************
  always_comb
  begin
    if (reg_addr_i == `OFS_IRQ_FLAGS)
    begin
      rd_value = r.flags;
    end
    else if (reg_addr_i == `OFS_LIVE_FLAGS)
    begin
      rd_value = live;
    end
    else if (reg_addr_i == `OFS_IRQ_MASK)
    begin
      rd_value = r.mask;
    end
    else if (reg_addr_i == `OFS_DRIVER_PARAMS)
    begin
      rd_value = r.params;
    end
    else if (reg_addr_i == `OFS_CTRL_A)
    begin
      rd_value = r.ctrl_a;
    end
    else if (reg_addr_i == `OFS_CTRL_B)
    begin
      rd_value = r.ctrl_b;
    end
    else if (reg_addr_i == `OFS_PROT_DISABLE)
    begin
      rd_value = r.prot;
    end
    else if (reg_addr_i == `OFS_HOST_ROLE)
    begin
      rd_value = r.role;
    end
    else if (reg_addr_i == `OFS_SILICON_REV)
    begin
      rd_value = SILICON_REV;
    end
    else
    begin
      rd_value = 8'h00;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;

    // ****************************************
    // Overload qualification
    // ****************************************
    if (!ovl_allowed)
    begin
      next_r.ovl_cnt = 16'h0000;
      next_r.ovl_live = 1'b0;
    end
    else if (c.overcurrent)
    begin
      if (r.ovl_cnt > blank_lim)
      begin
        next_r.ovl_live = 1'b1;
      end
      else
      begin
        next_r.ovl_cnt = r.ovl_cnt + 16'h0001;
      end
    end
    else
    begin
      next_r.ovl_cnt = 16'h0000;
      next_r.ovl_live = 1'b0;
    end

    // ****************************************
    // Wake latch; a low transmit enable wins
    // ****************************************
    if (!c.transmit_enable)
    begin
      next_r.wake_live = 1'b0;
    end
    else if (c.wake_detect)
    begin
      next_r.wake_live = 1'b1;
    end

    // ****************************************
    // Supply and thermal disables only keep the driver on; their events still record
    // ****************************************
    next_r.shut_live = (c.supply_shutdown && !r.prot[`BIT_DIS_SUPPLY]) ||
                       (c.thermal_shutdown && !r.prot[`BIT_DIS_THERMAL]);

    // ****************************************
    // Integrity sampled only while starting up
    // ****************************************
    case (r.phase)
      PH_STARTUP:
      begin
        next_r.die_fault = c.die_broken;
        if (r.start_cnt >= 16'(STARTUP_CYCLES - 1))
        begin
          next_r.phase = PH_RUN;
        end
        else
        begin
          next_r.start_cnt = r.start_cnt + 16'h0001;
        end
      end
      default:
      begin
        next_r.die_fault = r.die_fault;
      end
    endcase

    // ****************************************
    // Read clears all; new events win over the clear
    // ****************************************
    if (flags_read)
    begin
      next_r.flags = events;
    end
    else
    begin
      next_r.flags = r.flags | events;
    end

    // ****************************************
    // Register writes
    // ****************************************
    next_r.rvalid = reg_rd_i;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `OFS_IRQ_MASK)
      begin
        next_r.mask = reg_wdata_i;
      end
      else if (reg_addr_i == `OFS_DRIVER_PARAMS)
      begin
        next_r.params = reg_wdata_i;
      end
      else if (reg_addr_i == `OFS_CTRL_A)
      begin
        next_r.ctrl_a = reg_wdata_i;
      end
      else if (reg_addr_i == `OFS_CTRL_B)
      begin
        next_r.ctrl_b = reg_wdata_i;
      end
      else if (reg_addr_i == `OFS_PROT_DISABLE)
      begin
        next_r.prot = reg_wdata_i & `WMASK_PROT_DISABLE;
      end
      else if (reg_addr_i == `OFS_HOST_ROLE)
      begin
        next_r.role = reg_wdata_i & `WMASK_HOST_ROLE;
      end
    end

    // ****************************************
    // Read data, value as it stands in the read cycle
    // ****************************************
    if (reg_rd_i)
    begin
      next_r.rdata = rd_value;
    end

    // Pin is shared with the link, so hold off while a frame runs
    next_r.diag_oe = (|pending) && link_idle_i;
  end

  // ****************************************
  // Live condition view
  // ****************************************
  always_comb
  begin
    live = 8'h00;
    live[`BIT_RECEIVE_LEVEL] = c.receive_level;
    live[`BIT_SHUTDOWN_LIVE] = r.shut_live;
    live[`BIT_THERMAL_WARNING] = c.thermal_warning;
    live[`BIT_SUPPLY_LOW] = c.supply_low;
    live[`BIT_SUPPLY_HIGH] = c.supply_high;
    live[`BIT_WAKE] = r.wake_live;
    live[`BIT_OVERCURRENT] = r.ovl_live;
    live[`BIT_DIE_BROKEN] = r.die_fault;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.flags <= `RST_IRQ_FLAGS;
      r.mask <= `RST_IRQ_MASK;
      r.params <= `RST_DRIVER_PARAMS;
      r.ctrl_a <= `RST_CTRL_A;
      r.ctrl_b <= `RST_CTRL_B;
      r.prot <= `RST_PROT_DISABLE;
      r.role <= `RST_HOST_ROLE;
      r.phase <= PH_STARTUP;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = r.rdata;
  assign reg_rvalid_o = r.rvalid;
  // Open drain: level fixed low, only the enable moves
  assign serial_diag_pin_o = 1'b0;
  assign serial_diag_pin_oe_o = r.diag_oe;
  assign driver_shutdown_o = r.shut_live;
  assign driver_params_o = r.params;
  assign transceiver_ctrl_a_o = r.ctrl_a;
  assign transceiver_ctrl_b_o = r.ctrl_b;
  assign protection_disable_o = r.prot;
  assign host_role_cfg_o = r.role;

endmodule
